// ---- include/psl_pkg.sv ----
// Constants, register map and carrier types of the protection status logic.
//
// Overview of operation
// - Accessory-low flag reads 1 while accessory sense is below selected threshold.
// - Accessory detect pin is held low while accessory-low is present.
// - Accessory-low never changes any rail enable.
// - Surge trip on core or load supply sets its fault flag bit.
// - Surge trip switches off every rail except the always-on rail.
// - Surge trip releases only when both supplies are below release level.
// - Surge trip clears the power enable register; host must rewrite it.
// - Battery detect pin is held low throughout a surge trip.
// - Overheat cutoff turns off all rails, always-on rail included.
// - After overheat clears, always-on rail and serial control return.
// - Thermal warning sets the thermal warning flag.
// - Thermal warning flag clears below its lower release level.
// - Thermal warning leaves every rail enable unchanged.
// - Thermal warning pulls battery detect low only when mode bit is 1.
// - Low or high load supply pulls battery detect low in either mode.
// - Fault flag register carries accessory-low in bit 7, others below.
// - Battery output mode bit selects warning on battery detect; resets 0.
// - Each power enable bit turns its rail on at 1, off at 0.

package psl_pkg;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_POWER = 8'h00;
   localparam logic [7:0] ADDR_VOLT = 8'h01;
   localparam logic [7:0] ADDR_SENSE = 8'h02;
   localparam logic [7:0] ADDR_FLAGS = 8'h03;
   localparam logic [7:0] ADDR_PINS = 8'h04;

   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [7:0] VOLT_RESET = 8'h00;
   localparam logic [7:0] SENSE_RESET = 8'h00;
   localparam logic [7:0] POWER_WMASK = 8'hF8;
   localparam logic [7:0] VOLT_WMASK = 8'hFE;
   localparam logic [7:0] SENSE_WMASK = 8'hFB;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int RAIL_COUNT = 5;
   localparam int POWER_RAIL_LSB = 3;
   localparam int SENSE_ACC_LSB = 6;
   localparam int SENSE_LOW_LSB = 4;
   localparam int SENSE_MODE_BIT = 3;
   localparam int FLAG_ACC_LOW = 7;
   localparam int FLAG_LOW_SUPPLY = 6;
   localparam int FLAG_HIGH_SUPPLY = 5;
   localparam int FLAG_SURGE = 4;
   localparam int FLAG_WARN = 3;
   localparam int FLAG_OVER_CURRENT = 2;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // Carrier of raw comparator indications
   // ----------------------------------------------------------------
   typedef struct packed {
      logic acc_low;
      logic core_above_trip;
      logic core_above_release;
      logic load_above_trip;
      logic load_above_release;
      logic load_low;
      logic load_high;
      logic heat_above_cutoff;
      logic heat_above_restore;
      logic heat_above_warn;
      logic heat_above_warn_release;
      logic over_current;
   } psl_sense_t;

   typedef enum logic {
      PSL_TRIP_IDLE,
      PSL_TRIP_ACTIVE
   } psl_trip_t;

endpackage

// ---- hdl/psl_sync.sv ----
// Multi-bit two-flop synchroniser for independent comparator levels.
`timescale 1ns/1ps

module psl_sync #(
   parameter int WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Each bit is an independent level, so bitwise crossing is safe.
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// ---- hdl/psl_top.sv ----
// Protection, fault flags, indicator pins and rail enables of the supply.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module psl_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire psl_pkg::psl_sense_t sense_raw,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic acc_detect_in,
   output logic acc_detect_out,
   output logic acc_detect_oe_n,
   input wire logic battery_detect_in,
   output logic battery_detect_out,
   output logic battery_detect_oe_n,
   output logic [4:0] rail_enable,
   output logic always_on_enable,
   output logic serial_ctrl_ready,
   output logic [1:0] acc_threshold_sel,
   output logic [1:0] low_threshold_sel,
   output logic [7:0] voltage_sel
);

   // ----------------------------------------------------------------
   // Hysteresis decode
   // ----------------------------------------------------------------

   // A condition is entered on its upper comparator and left only
   // when its lower comparator drops, so noise near one level cannot
   // make the state chatter.
   function automatic logic hyst_next(
      input logic state,
      input logic above_hi,
      input logic above_lo
   );
      hyst_next = above_hi | (state & above_lo);
   endfunction

   // ----------------------------------------------------------------
   // Synchronised comparator levels
   // ----------------------------------------------------------------
   psl_pkg::psl_sense_t sense;
   logic [$bits(psl_pkg::psl_sense_t)-1:0] sense_bits;

   psl_sync #(
      .WIDTH($bits(psl_pkg::psl_sense_t))
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in(sense_raw),
      .sync_out(sense_bits)
   );

   assign sense = psl_pkg::psl_sense_t'(sense_bits);

   // ----------------------------------------------------------------
   // Protection states
   // ----------------------------------------------------------------
   psl_pkg::psl_trip_t trip_state;
   psl_pkg::psl_trip_t next_trip_state;
   logic overheat;
   logic next_overheat;
   logic warning;
   logic next_warning;
   logic surge_enter;
   logic surge_clear;

   // Either supply may trip; release needs both below the lower level.
   assign surge_enter = sense.core_above_trip | sense.load_above_trip;
   assign surge_clear = ~sense.core_above_release
      & ~sense.load_above_release;

   always_comb begin
      case (trip_state)
         psl_pkg::PSL_TRIP_IDLE: begin
            if (surge_enter) begin
               next_trip_state = psl_pkg::PSL_TRIP_ACTIVE;
            end else begin
               next_trip_state = psl_pkg::PSL_TRIP_IDLE;
            end
         end
         psl_pkg::PSL_TRIP_ACTIVE: begin
            if (surge_clear && !surge_enter) begin
               next_trip_state = psl_pkg::PSL_TRIP_IDLE;
            end else begin
               next_trip_state = psl_pkg::PSL_TRIP_ACTIVE;
            end
         end
         default: begin
            next_trip_state = psl_pkg::PSL_TRIP_IDLE;
         end
      endcase
   end

   assign next_overheat = hyst_next(overheat, sense.heat_above_cutoff,
      sense.heat_above_restore);
   assign next_warning = hyst_next(warning, sense.heat_above_warn,
      sense.heat_above_warn_release);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         trip_state <= psl_pkg::PSL_TRIP_IDLE;
         overheat <= 1'b0;
         warning <= 1'b0;
      end else begin
         trip_state <= next_trip_state;
         overheat <= next_overheat;
         warning <= next_warning;
      end
   end

   logic surge_trip;
   assign surge_trip = (trip_state == psl_pkg::PSL_TRIP_ACTIVE);

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------
   logic [7:0] power_enable_reg;
   logic [7:0] volt_ctrl_reg;
   logic [7:0] sense_config;
   logic [7:0] next_power;
   logic [7:0] next_volt;
   logic [7:0] next_sense;
   logic write_ok;
   logic wr_power;
   logic wr_volt;
   logic wr_sense;

   // Writes are refused while the overheat cutoff holds, since the
   // serial control path is out of service until it clears.
   assign write_ok = reg_wr & ~overheat;
   assign wr_power = write_ok && (reg_addr == psl_pkg::ADDR_POWER);
   assign wr_volt = write_ok && (reg_addr == psl_pkg::ADDR_VOLT);
   assign wr_sense = write_ok && (reg_addr == psl_pkg::ADDR_SENSE);

   // A surge trip holds the enable register at its reset value for the
   // whole trip, so a write made during the trip is lost as well.
   assign next_power = surge_trip ? psl_pkg::POWER_RESET
      : wr_power ? (reg_wdata & psl_pkg::POWER_WMASK)
      : power_enable_reg;
   assign next_volt = wr_volt ? (reg_wdata & psl_pkg::VOLT_WMASK)
      : volt_ctrl_reg;
   assign next_sense = wr_sense ? (reg_wdata & psl_pkg::SENSE_WMASK)
      : sense_config;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         power_enable_reg <= psl_pkg::POWER_RESET;
         volt_ctrl_reg <= psl_pkg::VOLT_RESET;
         sense_config <= psl_pkg::SENSE_RESET;
      end else begin
         power_enable_reg <= next_power;
         volt_ctrl_reg <= next_volt;
         sense_config <= next_sense;
      end
   end

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   logic battery_out_mode;
   logic [1:0] acc_sel_field;
   logic [1:0] low_sel_field;

   assign battery_out_mode = sense_config[psl_pkg::SENSE_MODE_BIT];
   assign acc_sel_field = sense_config[psl_pkg::SENSE_ACC_LSB +: 2];
   assign low_sel_field = sense_config[psl_pkg::SENSE_LOW_LSB +: 2];

   // ----------------------------------------------------------------
   // Fault flags
   // ----------------------------------------------------------------
   logic [7:0] fault_flags;
   logic acc_low_flag;
   logic low_supply_flag;
   logic high_supply_flag;

   // Flags mirror the live condition; nothing here is sticky.
   assign acc_low_flag = sense.acc_low;
   assign low_supply_flag = sense.load_low;
   assign high_supply_flag = sense.load_high;

   always_comb begin
      fault_flags = 8'h00;
      fault_flags[psl_pkg::FLAG_ACC_LOW] = acc_low_flag;
      fault_flags[psl_pkg::FLAG_LOW_SUPPLY] = low_supply_flag;
      fault_flags[psl_pkg::FLAG_HIGH_SUPPLY] = high_supply_flag;
      fault_flags[psl_pkg::FLAG_SURGE] = surge_trip;
      fault_flags[psl_pkg::FLAG_WARN] = warning;
      fault_flags[psl_pkg::FLAG_OVER_CURRENT] = sense.over_current;
   end

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   logic [7:0] read_mux;
   logic [7:0] pin_levels;
   logic [7:0] next_rdata;

   assign pin_levels = {6'h00, battery_detect_in, acc_detect_in};

   always_comb begin
      case (reg_addr)
         psl_pkg::ADDR_POWER: read_mux = power_enable_reg;
         psl_pkg::ADDR_VOLT: read_mux = volt_ctrl_reg;
         psl_pkg::ADDR_SENSE: read_mux = sense_config;
         psl_pkg::ADDR_FLAGS: read_mux = fault_flags;
         psl_pkg::ADDR_PINS: read_mux = pin_levels;
         default: read_mux = 8'h00;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe.
   assign next_rdata = reg_rd ? read_mux : 8'h00;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Rail enables
   // ----------------------------------------------------------------
   logic [4:0] next_rail;
   logic [4:0] rail_bits;

   assign rail_bits =
      power_enable_reg[psl_pkg::POWER_RAIL_LSB +: psl_pkg::RAIL_COUNT];

   // Accessory-low and thermal warning have no path into this gating,
   // which keeps the rails where the host left them.
   genvar g;
   generate
      for (g = 0; g < psl_pkg::RAIL_COUNT; g++) begin : gen_rail
         assign next_rail[g] = rail_bits[g] & ~surge_trip
            & ~overheat;
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rail_enable <= 5'h00;
         always_on_enable <= 1'b0;
         serial_ctrl_ready <= 1'b0;
      end else begin
         rail_enable <= next_rail;
         always_on_enable <= ~overheat;
         serial_ctrl_ready <= ~overheat;
      end
   end

   // ----------------------------------------------------------------
   // Open-drain indicator pins
   // ----------------------------------------------------------------
   logic acc_pull;
   logic battery_pull;

   assign acc_pull = acc_low_flag;
   assign battery_pull = low_supply_flag | high_supply_flag
      | surge_trip
      | (battery_out_mode & warning);

   // Pins only ever pull low; the output level stays 0 and the enable
   // decides, so the external pull-up makes the high level.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_detect_out <= 1'b0;
         acc_detect_oe_n <= 1'b1;
         battery_detect_out <= 1'b0;
         battery_detect_oe_n <= 1'b1;
      end else begin
         acc_detect_out <= 1'b0;
         acc_detect_oe_n <= ~acc_pull;
         battery_detect_out <= 1'b0;
         battery_detect_oe_n <= ~battery_pull;
      end
   end

   // ----------------------------------------------------------------
   // Threshold selects to the analog comparators
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         acc_threshold_sel <= 2'h0;
         low_threshold_sel <= 2'h0;
         voltage_sel <= psl_pkg::VOLT_RESET;
      end else begin
         acc_threshold_sel <= acc_sel_field;
         low_threshold_sel <= low_sel_field;
         voltage_sel <= volt_ctrl_reg;
      end
   end

endmodule

// ---- verification/psl_chk.sv ----
// Port-level assertion checker for the protection status logic.
`timescale 1ns/1ps

module psl_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire psl_pkg::psl_sense_t sense_raw,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic acc_detect_oe_n,
   input wire logic battery_detect_oe_n,
   input wire logic [4:0] rail_enable,
   input wire logic always_on_enable,
   input wire logic serial_ctrl_ready
);
   // Edges since reset, so that no history check reaches into reset.
   logic [2:0] up;
   always_ff @(posedge clock) begin
      if (!rst_n) up <= 3'h0;
      else if (up != 3'h7) up <= up + 3'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_acc_pin_live: assert property (up == 3'h7 |->
      acc_detect_oe_n == !$past(sense_raw.acc_low, 3))
      else $error("accessory pin does not follow accessory low");
   a_acc_sync_delay: assert property ((up == 3'h7 &&
      !sense_raw.acc_low) ##1 !sense_raw.acc_low [*2] ##1
      sense_raw.acc_low |-> acc_detect_oe_n [*3])
      else $error("accessory pin reacts before synchronisation");
   a_surge_rails_off: assert property ((up == 3'h7 &&
      (sense_raw.core_above_trip || sense_raw.load_above_trip))
      |-> ##4 rail_enable == 5'h00)
      else $error("rails stay on during surge trip");
   a_surge_batt_low: assert property ((up == 3'h7 &&
      (sense_raw.core_above_trip || sense_raw.load_above_trip))
      |-> ##4 !battery_detect_oe_n)
      else $error("battery pin released during surge trip");
   a_heat_all_off: assert property ((up == 3'h7 &&
      sense_raw.heat_above_cutoff) |-> ##4 (!always_on_enable &&
      !serial_ctrl_ready && rail_enable == 5'h00))
      else $error("outputs on during overheat");
   a_heat_restore: assert property ((up == 3'h7 &&
      !sense_raw.heat_above_restore) |-> ##4
      (always_on_enable && serial_ctrl_ready))
      else $error("always-on rail not restored after overheat");
   a_batt_range: assert property ((up == 3'h7 &&
      (sense_raw.load_low || sense_raw.load_high)) |-> ##3
      !battery_detect_oe_n)
      else $error("battery pin released on load supply range");
   // The read edge sees the synchroniser output, which lags the pins by
   // two edges, and the data show one edge later: three edges in all.
   a_flag_read: assert property ((up == 3'h7 && $past(reg_rd) &&
      $past(reg_addr) == psl_pkg::ADDR_FLAGS) |->
      {reg_rdata[7:5], reg_rdata[2]} == {$past(sense_raw.acc_low, 3),
      $past(sense_raw.load_low, 3), $past(sense_raw.load_high, 3),
      $past(sense_raw.over_current, 3)})
      else $error("fault flag read does not match detectors");
endmodule

bind psl_top psl_chk u_chk (.clock(clock), .rst_n(rst_n),
   .sense_raw(sense_raw), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .acc_detect_oe_n(acc_detect_oe_n),
   .battery_detect_oe_n(battery_detect_oe_n), .rail_enable(rail_enable),
   .always_on_enable(always_on_enable),
   .serial_ctrl_ready(serial_ctrl_ready));

// ---- verification/psl_pins.sv ----
// Board model of the two open-drain indicator pins and their pull-ups.
`timescale 1ns/1ps

module psl_pins (
   input wire logic acc_detect_out,
   input wire logic acc_detect_oe_n,
   input wire logic battery_detect_out,
   input wire logic battery_detect_oe_n,
   output logic acc_detect_in,
   output logic battery_detect_in
);
   // A released pin is pulled high by its board resistor.
   assign acc_detect_in = acc_detect_oe_n ? 1'b1 : acc_detect_out;
   assign battery_detect_in = battery_detect_oe_n ? 1'b1 : battery_detect_out;
endmodule

// ---- verification/tb_protection_status_logic.sv ----
// Directed register and detector testbench for the protection status logic.
`timescale 1ns/1ps

module tb_protection_status_logic;
   localparam logic [7:0] PW = psl_pkg::ADDR_POWER;
   localparam logic [7:0] SN = psl_pkg::ADDR_SENSE;
   localparam logic [7:0] FL = psl_pkg::ADDR_FLAGS;
   logic clock, rst_n, reg_wr, reg_rd, aon, rdy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, vsel;
   logic acc_in, acc_out, acc_oe_n, bat_in, bat_out, bat_oe_n;
   logic [4:0] rails;
   logic [1:0] acc_sel, low_sel;
   logic [7:0] ad [3];
   logic [7:0] mk [3];
   psl_pkg::psl_sense_t sense, v;
   int n_errors, checked;

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   psl_top dut (.clock(clock), .rst_n(rst_n), .sense_raw(sense),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_detect_in(acc_in),
      .acc_detect_out(acc_out), .acc_detect_oe_n(acc_oe_n),
      .battery_detect_in(bat_in), .battery_detect_out(bat_out),
      .battery_detect_oe_n(bat_oe_n), .rail_enable(rails),
      .always_on_enable(aon), .serial_ctrl_ready(rdy),
      .acc_threshold_sel(acc_sel), .low_threshold_sel(low_sel),
      .voltage_sel(vsel));
   psl_pins pins (.acc_detect_out(acc_out), .acc_detect_oe_n(acc_oe_n),
      .battery_detect_out(bat_out), .battery_detect_oe_n(bat_oe_n),
      .acc_detect_in(acc_in), .battery_detect_in(bat_in));

   // ------------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] got);
      checked++;
      if (got !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk(nm, e, reg_rdata);
   endtask
   // Detector changes settle well inside six edges.
   task automatic go(input psl_pkg::psl_sense_t x);
      @(posedge clock);
      sense <= x;
      tick(6);
   endtask
   task automatic wrap_up;
      $display("mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_errors++;
      wrap_up;
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      sense = '0;
      n_errors = 0;
      checked = 0;
      ad = '{PW, psl_pkg::ADDR_VOLT, SN};
      mk = '{8'hF8, 8'hFE, 8'hFB};
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      tick(3);
      rd(PW, 8'h00, "power");
      rd(SN, 8'h00, "sense");
      rd(FL, 8'h00, "flags");
      for (int i = 0; i < 3; i++) begin
         wr(ad[i], 8'hFF);
         rd(ad[i], mk[i], "mask");
      end
      chk("selects", 8'h0F, {4'h0, acc_sel, low_sel});
      chk("volt sel", 8'hFE, vsel);
      wr(SN, 8'h00);
      wr(PW, 8'hA8);
      tick(3);
      chk("rails", 8'h15, {3'h0, rails});
      v = '0;
      v.acc_low = 1'b1;
      go(v);
      chk("acc pin", 8'h00, {7'h00, acc_in});
      rd(psl_pkg::ADDR_PINS, 8'h02, "pins");
      rd(FL, 8'h80, "flags");
      chk("rails", 8'h15, {3'h0, rails});
      v = '0;
      v.over_current = 1'b1;
      go(v);
      rd(FL, 8'h04, "flags");
      v = '0;
      go(v);
      rd(FL, 8'h00, "flags");
      chk("acc pin", 8'h01, {7'h00, acc_in});
      for (int i = 0; i < 4; i++) begin
         wr(SN, i[1] ? 8'h08 : 8'h00);
         v.load_low = !i[0];
         v.load_high = i[0];
         go(v);
         chk("bat pin", 8'h00, {7'h00, bat_in});
         rd(FL, i[0] ? 8'h20 : 8'h40, "flags");
         chk("rails", 8'h15, {3'h0, rails});
      end
      wr(SN, 8'h00);
      v = '0;
      v.heat_above_warn = 1'b1;
      v.heat_above_warn_release = 1'b1;
      go(v);
      rd(FL, 8'h08, "flags");
      chk("bat pin", 8'h01, {7'h00, bat_in});
      chk("rails", 8'h15, {3'h0, rails});
      wr(SN, 8'h08);
      tick(4);
      chk("bat pin", 8'h00, {7'h00, bat_in});
      v.heat_above_warn = 1'b0;
      go(v);
      rd(FL, 8'h08, "flags");
      v = '0;
      go(v);
      rd(FL, 8'h00, "flags");
      chk("bat pin", 8'h01, {7'h00, bat_in});
      for (int i = 0; i < 2; i++) begin
         v.core_above_trip = (i == 0);
         v.core_above_release = (i == 0);
         v.load_above_trip = (i == 1);
         v.load_above_release = (i == 1);
         go(v);
         chk("rails", 8'h00, {3'h0, rails});
         chk("always on", 8'h01, {7'h00, aon});
         chk("bat pin", 8'h00, {7'h00, bat_in});
         rd(FL, 8'h10, "flags");
         wr(PW, 8'hF8);
         rd(PW, 8'h00, "power");
         v.core_above_trip = 1'b0;
         v.load_above_trip = 1'b0;
         go(v);
         rd(FL, 8'h10, "flags");
         v = '0;
         go(v);
         rd(FL, 8'h00, "flags");
         chk("bat pin", 8'h01, {7'h00, bat_in});
         chk("rails", 8'h00, {3'h0, rails});
         wr(PW, 8'hF8);
         tick(3);
         chk("rails", 8'h1F, {3'h0, rails});
      end
      v.heat_above_cutoff = 1'b1;
      v.heat_above_restore = 1'b1;
      go(v);
      chk("heat", 8'h00, {1'b0, rails, aon, rdy});
      // A write while overheated must be lost.
      wr(PW, 8'h00);
      v.heat_above_cutoff = 1'b0;
      go(v);
      chk("always on", 8'h00, {7'h00, aon});
      v = '0;
      go(v);
      chk("restore", 8'h7F, {1'b0, rails, aon, rdy});
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      tick(3);
      chk("reset rails", 8'h01, {2'h0, rails, aon});
      rd(PW, 8'h00, "power");
      rd(SN, 8'h00, "sense");
      wrap_up;
   end
endmodule
